// ===== cbim_pkg.sv
// package: constants and carriers for the contactor bus image mapper
package cbim_pkg;

  // ------------------------------------------------------------
  // image geometry
  // ------------------------------------------------------------
  localparam int CBIM_NUM_SLAVES = 16;
  localparam int CBIM_IMG_BYTES = 8;
  localparam int CBIM_NIBBLE_W = 4;
  localparam int CBIM_COIL_BIT = 0;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] CBIM_OUT_IMG_LO = 8'h00;
  localparam logic [7:0] CBIM_OUT_IMG_HI = 8'h04;
  localparam logic [7:0] CBIM_DIAG_LO = 8'h08;
  localparam logic [7:0] CBIM_DIAG_HI = 8'h0C;
  localparam logic [7:0] CBIM_CTRL = 8'h10;
  localparam logic [7:0] CBIM_IRQ_STAT = 8'h14;
  localparam logic [7:0] CBIM_IRQ_EN = 8'h18;
  localparam logic [7:0] CBIM_IRQ_CLR = 8'h1C;
  localparam logic [7:0] CBIM_TYPE_ERR = 8'h20;
  localparam logic [7:0] CBIM_SLV_DIAG = 8'h24;
  localparam logic [7:0] CBIM_BRK_ERR = 8'h28;

  // ------------------------------------------------------------
  // diagnostic byte 1 and 2 bit positions
  // ------------------------------------------------------------
  localparam int CBIM_B1_MASTER_CFG = 0;
  localparam int CBIM_B1_HOST_CFG = 2;
  localparam int CBIM_B1_COMM = 4;
  localparam int CBIM_B1_BUS_SUP = 6;
  localparam int CBIM_B1_GENERAL = 7;
  localparam int CBIM_B2_SLV_DIAG = 1;
  localparam int CBIM_B2_BREAKER = 3;
  localparam int CBIM_B2_TYPE = 5;
  localparam int CBIM_B2_AUX_SUP = 6;

  // ------------------------------------------------------------
  // interrupt status bits
  // ------------------------------------------------------------
  localparam int CBIM_IRQ_W = 4;
  localparam int CBIM_IRQ_COMM = 0;
  localparam int CBIM_IRQ_CFG = 1;
  localparam int CBIM_IRQ_BRK = 2;
  localparam int CBIM_IRQ_TYPE = 3;

  // ------------------------------------------------------------
  // reset values and link timing
  // ------------------------------------------------------------
  localparam logic [63:0] CBIM_OUT_IMG_RST = 64'h0;
  localparam logic [CBIM_IRQ_W-1:0] CBIM_IRQ_EN_RST = 4'h0;
  localparam logic [0:0] CBIM_CTRL_RST = 1'h0;
  localparam logic [CBIM_IRQ_W-1:0] CBIM_EVT_PREV_RST = 4'h2;
  localparam logic [7:0] CBIM_BIT_DIV = 8'h31;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } cbim_bus_req_t;

  typedef struct packed {
    logic master_config_error;
    logic host_config_error;
    logic link_comm_error;
    logic bus_supply_error;
    logic aux_supply_error;
    logic [CBIM_NUM_SLAVES-1:0] type_mismatch_flag;
    logic [CBIM_NUM_SLAVES-1:0] slave_diag_flag;
    logic [CBIM_NUM_SLAVES-1:0] breaker_trip_flag;
  } cbim_status_t;

endpackage : cbim_pkg

// ===== cbim_sync.sv
// three-stage input synchroniser with agreement filter
module cbim_sync
  import cbim_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end
    else
    begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // change accepted only where stages two and three agree
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      sync_out <= '0;
    else
      sync_out <= (s2_reg & s3_reg) | (sync_out & (s2_reg | s3_reg));
  end

endmodule : cbim_sync

// ===== cbim_tx.sv
// serial transmitter of coil commands to addressed slaves
module cbim_tx
  import cbim_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [CBIM_NUM_SLAVES-1:0] coil_cmd,
  output logic tx_data,
  output logic tx_frame,
  output logic [3:0] tx_addr
);

  typedef enum logic [1:0] {TX_IDLE, TX_SEND} cbim_tx_state_t;
  cbim_tx_state_t state_reg;
  logic [7:0] div_reg;
  logic bit_tick;

  // bit-rate enable pulse
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_reg <= 8'h00;
    else if (div_reg == CBIM_BIT_DIV)
      div_reg <= 8'h00;
    else
      div_reg <= div_reg + 8'h01;
  end

  assign bit_tick = (div_reg == CBIM_BIT_DIV);

  // one slave per bit slot, index order follows physical order
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= TX_IDLE;
      tx_addr <= 4'h0;
      tx_data <= 1'b0;
      tx_frame <= 1'b0;
    end
    else if (bit_tick)
    begin
      case (state_reg)
        TX_IDLE:
        begin
          tx_frame <= 1'b0;
          tx_data <= 1'b0;
          if (enable)
          begin
            state_reg <= TX_SEND;
            tx_addr <= 4'h0;
            tx_frame <= 1'b1;
            tx_data <= coil_cmd[0];
          end
        end
        TX_SEND:
        begin
          if (tx_addr == 4'hF)
          begin
            state_reg <= TX_IDLE;
            tx_frame <= 1'b0;
            tx_data <= 1'b0;
          end
          else
          begin
            tx_addr <= tx_addr + 4'h1;
            tx_data <= coil_cmd[tx_addr + 4'h1];
          end
        end
        default:
          state_reg <= TX_IDLE;
      endcase
    end
  end

endmodule : cbim_tx

// ===== cbim_top.sv
// top of the contactor bus image mapper: images, registers, interrupt
//
// Operation
// - output image is eight bytes, for up to sixteen slaves
// - byte n: slave 2n-1 in low nibble, slave 2n in high
// - slave index 1 is first physical slave, then consecutive
// - coil command is nibble bit 0; upper three bits ignored
// - command 0 means contactor off, 1 means on
// - each coil command is sent to its addressed slave
// - diag byte 1: master cfg, host cfg, comm, supply, general
// - diag byte 2: slave diag, breaker, type summaries, aux supply
// - diag bytes 3 and 4: per-slave type mismatch flags
// - diag bytes 5 and 6: per-slave slave-diagnostics flags
// - diag bytes 7 and 8: per-slave breaker flags
// - master cfg error 0 in data exchange, 1 when offline
// - comm error set when any slave unreachable; slave diagnostics do not set it
module cbim_top
  import cbim_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire cbim_pkg::cbim_bus_req_t bus_req,
  output logic [31:0] rdata,
  input wire logic cfg_accepted,
  input wire logic host_cfg_fault,
  input wire logic bus_supply_fault,
  input wire logic aux_supply_fault,
  input wire logic [cbim_pkg::CBIM_NUM_SLAVES-1:0] slave_unreachable,
  input wire logic [cbim_pkg::CBIM_NUM_SLAVES-1:0] slave_type_bad,
  input wire logic [cbim_pkg::CBIM_NUM_SLAVES-1:0] slave_diag_in,
  input wire logic [cbim_pkg::CBIM_NUM_SLAVES-1:0] slave_breaker_in,
  output logic [cbim_pkg::CBIM_NUM_SLAVES-1:0] coil_out,
  output logic link_tx_data,
  output logic link_tx_frame,
  output logic [3:0] link_tx_addr,
  output logic [63:0] diag_image,
  output logic irq
);

  import cbim_pkg::*;

  // ------------------------------------------------------------
  // input synchronisation
  // ------------------------------------------------------------
  localparam int SYNC_W = 4 + 4 * CBIM_NUM_SLAVES;
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync_in;
  cbim_status_t st;

  assign raw_in = {cfg_accepted, host_cfg_fault, bus_supply_fault,
                   aux_supply_fault, slave_unreachable, slave_type_bad,
                   slave_diag_in, slave_breaker_in};

  cbim_sync #(.W(SYNC_W)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(raw_in),
    .sync_out(sync_in)
  );

  logic cfg_ok;
  assign cfg_ok = sync_in[SYNC_W-1];
  assign st.master_config_error = ~cfg_ok;
  assign st.host_config_error = sync_in[SYNC_W-2];
  assign st.bus_supply_error = sync_in[SYNC_W-3];
  assign st.aux_supply_error = sync_in[SYNC_W-4];
  assign st.link_comm_error = |sync_in[63:48];
  assign st.type_mismatch_flag = sync_in[47:32];
  assign st.slave_diag_flag = sync_in[31:16];
  assign st.breaker_trip_flag = sync_in[15:0];

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [63:0] out_img_reg;
  logic [0:0] ctrl_reg;
  logic [CBIM_IRQ_W-1:0] irq_stat_reg;
  logic [CBIM_IRQ_W-1:0] irq_en_reg;
  logic [CBIM_IRQ_W-1:0] irq_event;
  logic [CBIM_IRQ_W-1:0] evt_src;
  logic [CBIM_IRQ_W-1:0] evt_prev_reg;
  logic [CBIM_IRQ_W-1:0] clr_mask;
  logic [CBIM_NUM_SLAVES-1:0] coil_cmd;
  logic [63:0] diag_next;
  logic [31:0] rdata_next;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      out_img_reg <= CBIM_OUT_IMG_RST;
    else if (bus_req.wr && bus_req.addr == CBIM_OUT_IMG_LO)
      out_img_reg[31:0] <= bus_req.wdata;
    else if (bus_req.wr && bus_req.addr == CBIM_OUT_IMG_HI)
      out_img_reg[63:32] <= bus_req.wdata;
  end

  // transmit enable
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_reg <= CBIM_CTRL_RST;
    else if (bus_req.wr && bus_req.addr == CBIM_CTRL)
      ctrl_reg <= bus_req.wdata[0:0];
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_en_reg <= CBIM_IRQ_EN_RST;
    else if (bus_req.wr && bus_req.addr == CBIM_IRQ_EN)
      irq_en_reg <= bus_req.wdata[CBIM_IRQ_W-1:0];
  end

  // ------------------------------------------------------------
  // output image unpacking
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < CBIM_NUM_SLAVES; gi++)
    begin : g_coil
      // slave gi+1 at nibble gi; only the command bit is used
      assign coil_cmd[gi] =
        out_img_reg[gi*CBIM_NIBBLE_W + CBIM_COIL_BIT];
    end
  endgenerate

  // 1 drives coil on, 0 off
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      coil_out <= '0;
    else
      coil_out <= coil_cmd;
  end

  cbim_tx u_tx (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .enable(ctrl_reg[0] & cfg_ok),
    .coil_cmd(coil_cmd),
    .tx_data(link_tx_data),
    .tx_frame(link_tx_frame),
    .tx_addr(link_tx_addr)
  );

  // ------------------------------------------------------------
  // diagnostic image
  // ------------------------------------------------------------
  always_comb
  begin
    diag_next = 64'h0;
    diag_next[CBIM_B1_MASTER_CFG] = st.master_config_error;
    diag_next[CBIM_B1_HOST_CFG] = st.host_config_error;
    diag_next[CBIM_B1_COMM] = st.link_comm_error;
    diag_next[CBIM_B1_BUS_SUP] = st.bus_supply_error;
    diag_next[CBIM_B1_GENERAL] = st.master_config_error |
      st.host_config_error | st.link_comm_error | st.bus_supply_error |
      st.aux_supply_error;
    diag_next[8 + CBIM_B2_SLV_DIAG] = |st.slave_diag_flag;
    diag_next[8 + CBIM_B2_BREAKER] = |st.breaker_trip_flag;
    diag_next[8 + CBIM_B2_TYPE] = |st.type_mismatch_flag;
    diag_next[8 + CBIM_B2_AUX_SUP] = st.aux_supply_error;
    diag_next[31:16] = st.type_mismatch_flag;
    diag_next[47:32] = st.slave_diag_flag;
    diag_next[63:48] = st.breaker_trip_flag;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      diag_image <= 64'h0;
    else
      diag_image <= diag_next;
  end

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  assign evt_src = {diag_next[8 + CBIM_B2_TYPE],
                    diag_next[8 + CBIM_B2_BREAKER],
                    diag_next[CBIM_B1_MASTER_CFG],
                    diag_next[CBIM_B1_COMM]};
  assign irq_event = evt_src & ~evt_prev_reg;
  assign clr_mask = (bus_req.wr && bus_req.addr == CBIM_IRQ_CLR) ?
                    bus_req.wdata[CBIM_IRQ_W-1:0] : '0;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    // master cfg error idles high out of reset: no false event
    if (!rst_n)
      evt_prev_reg <= CBIM_EVT_PREV_RST;
    else
      evt_prev_reg <= evt_src;
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_stat_reg <= '0;
    else
      irq_stat_reg <= (irq_stat_reg & ~clr_mask) | irq_event;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(((irq_stat_reg & ~clr_mask) | irq_event) & irq_en_reg);
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  always_comb
  begin
    rdata_next = 32'h0;
    if (bus_req.addr == CBIM_OUT_IMG_LO)
      rdata_next = out_img_reg[31:0];
    else if (bus_req.addr == CBIM_OUT_IMG_HI)
      rdata_next = out_img_reg[63:32];
    else if (bus_req.addr == CBIM_DIAG_LO)
      rdata_next = diag_image[31:0];
    else if (bus_req.addr == CBIM_DIAG_HI)
      rdata_next = diag_image[63:32];
    else if (bus_req.addr == CBIM_CTRL)
      rdata_next = {31'h0, ctrl_reg};
    else if (bus_req.addr == CBIM_IRQ_STAT)
      rdata_next = {28'h0, irq_stat_reg};
    else if (bus_req.addr == CBIM_IRQ_EN)
      rdata_next = {28'h0, irq_en_reg};
    else if (bus_req.addr == CBIM_TYPE_ERR)
      rdata_next = {16'h0, diag_image[31:16]};
    else if (bus_req.addr == CBIM_SLV_DIAG)
      rdata_next = {16'h0, diag_image[47:32]};
    else if (bus_req.addr == CBIM_BRK_ERR)
      rdata_next = {16'h0, diag_image[63:48]};
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 32'h0;
    else if (bus_req.rd)
      rdata <= rdata_next;
    else
      rdata <= 32'h0;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_coil_follows: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    coil_out == $past(coil_cmd))
    else $error("coil output not following image");
  a_nibble_map: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    coil_out[1] == $past(out_img_reg[4]) &&
    coil_out[8] == $past(out_img_reg[32]) &&
    coil_out[15] == $past(out_img_reg[60]))
    else $error("nibble mapping wrong");
  a_upper_ignored: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (out_img_reg & 64'h1111_1111_1111_1111) ==
    ($past(out_img_reg) & 64'h1111_1111_1111_1111) |=> $stable(coil_out))
    else $error("coil changed without command bit change");
  a_unused_zero: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (diag_image[5] | diag_image[3] | diag_image[1] | diag_image[8]
     | diag_image[10] | diag_image[12] | diag_image[15]) == 1'b0)
    else $error("unused diagnostic bit set");
  a_master_cfg: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $past(rst_n) |-> diag_image[0] == ~$past(cfg_ok))
    else $error("master config flag wrong");
  a_offline_idle: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !link_tx_frame && !cfg_ok |=> !link_tx_frame)
    else $error("frame started while configuration not accepted");
  a_comm_flag: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    diag_image[4] == $past(|sync_in[63:48]))
    else $error("comm error flag wrong");
  a_breaker_sum: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    diag_image[11] == (|diag_image[63:48]))
    else $error("breaker summary mismatch");
  a_type_sum: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    diag_image[13] == (|diag_image[31:16]))
    else $error("type summary mismatch");
  a_diag_sum: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    diag_image[9] == (|diag_image[47:32]))
    else $error("slave diag summary mismatch");
  a_general_err: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    diag_image[7] == (diag_image[0] | diag_image[2] | diag_image[4] |
      diag_image[6] | diag_image[14]))
    else $error("general error not matching its sources");
  a_tx_addressed: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    link_tx_frame && ($rose(link_tx_frame) || $changed(link_tx_addr))
    |-> (($past(coil_cmd) >> link_tx_addr) & 16'h0001) ==
        {15'h0, link_tx_data})
    else $error("transmitted bit not the addressed slave command");
  a_first_slot: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $rose(link_tx_frame) |-> link_tx_addr == 4'h0)
    else $error("frame not opened at the first slave");
  a_last_slot: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $fell(link_tx_frame) |-> link_tx_addr == 4'hF)
    else $error("frame closed before the last slave");

endmodule : cbim_top

// ===== cbim_link_model.sv
// model of the contactor bus slaves listening on the coil link
module cbim_link_model
  import cbim_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic link_tx_data,
  input wire logic link_tx_frame,
  input wire logic [3:0] link_tx_addr,
  output logic [cbim_pkg::CBIM_NUM_SLAVES-1:0] rx_coils_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  import cbim_pkg::*;

  // ----
  // each slot latches the coil of the slave it addresses
  // ----
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rx_coils_reg <= '0;
    else if (link_tx_frame)
      rx_coils_reg[link_tx_addr] <= link_tx_data;
  end
endmodule : cbim_link_model

// ===== testbench.sv
// self-checking testbench for the contactor bus image mapper
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import cbim_pkg::*;

  logic core_clk;
  logic rst_n;
  cbim_bus_req_t bus_req;
  logic [31:0] rdata;
  logic cfg_accepted;
  logic host_f;
  logic bus_f;
  logic aux_f;
  logic [15:0] unr;
  logic [15:0] typ;
  logic [15:0] sd;
  logic [15:0] brk;
  logic [15:0] coil_out;
  logic [15:0] rx_coils;
  logic tx_d;
  logic tx_f;
  logic [3:0] tx_a;
  logic [63:0] diag;
  logic irq;
  logic [31:0] rd_v;
  logic [15:0] exp_coil;
  int n_errors;
  int compares;
  int cyc;

  cbim_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .bus_req(bus_req),
    .rdata(rdata), .cfg_accepted(cfg_accepted), .host_cfg_fault(host_f),
    .bus_supply_fault(bus_f), .aux_supply_fault(aux_f),
    .slave_unreachable(unr), .slave_type_bad(typ), .slave_diag_in(sd),
    .slave_breaker_in(brk), .coil_out(coil_out), .link_tx_data(tx_d),
    .link_tx_frame(tx_f), .link_tx_addr(tx_a), .diag_image(diag),
    .irq(irq));

  cbim_link_model link_u (.core_clk(core_clk), .rst_n(rst_n),
    .link_tx_data(tx_d), .link_tx_frame(tx_f), .link_tx_addr(tx_a),
    .rx_coils_reg(rx_coils));

  // ----
  // shared tasks
  // ----
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 rd_v = rdata;
  endtask : bus_rd

  function automatic logic [63:0] exp_diag();
    logic [7:0] b1;
    logic [7:0] b2;
    logic mc;
    logic cm;
    mc = ~cfg_accepted;
    cm = |unr;
    b1 = {mc | host_f | cm | bus_f | aux_f, bus_f, 1'b0, cm, 1'b0, host_f,
      1'b0, mc};
    b2 = {1'b0, aux_f, |typ, 1'b0, |brk, 1'b0, |sd, 1'b0};
    return {brk, sd, typ, b2, b1};
  endfunction : exp_diag

  // ----
  // scenarios
  // ----
  task automatic t_reset();
    check(coil_out, 64'h0);
    bus_rd(CBIM_OUT_IMG_LO);
    check(rd_v, 64'h0);
    bus_rd(CBIM_CTRL);
    check(rd_v, 64'h0);
    bus_rd(8'h3C);
    check(rd_v, 64'h0);
  endtask : t_reset

  task automatic t_out_image();
    logic [63:0] img [4];
    img = '{64'hFEDC_BA98_7654_3210, 64'hEEEE_EEEE_EEEE_EEEE,
      64'h1111_1111_1111_1111, 64'h0123_4567_89AB_CDEF};
    foreach (img[i])
    begin
      bus_wr(CBIM_OUT_IMG_LO, img[i][31:0]);
      bus_wr(CBIM_OUT_IMG_HI, img[i][63:32]);
      for (int k = 0; k < 16; k++)
        exp_coil[k] = img[i][4 * k];
      repeat (3) @(posedge core_clk);
      check(coil_out, exp_coil);
      bus_rd(CBIM_OUT_IMG_HI);
      check(rd_v, img[i][63:32]);
    end
  endtask : t_out_image

  task automatic t_diag();
    logic [63:0] ed;
    for (int i = 0; i < 5; i++)
    begin
      @(posedge core_clk);
      cfg_accepted <= (i == 0) || (i > 2);
      host_f <= (i == 1);
      bus_f <= (i == 2);
      aux_f <= (i == 3);
      unr <= (i == 2) ? 16'h0100 : 16'h0;
      typ <= (i < 4) ? 16'h0001 << (i * 5) : 16'h0;
      sd <= (i < 4) ? 16'h8000 >> (i * 3) : 16'h0;
      brk <= (i == 3) ? 16'hA5C3 : 16'h0;
      repeat (7) @(posedge core_clk);
      #1 ed = exp_diag();
      check(diag[7:0], ed[7:0]);
      check(diag[15:8], ed[15:8]);
      check(diag[31:16], ed[31:16]);
      check(diag[47:32], ed[47:32]);
      check(diag[63:48], ed[63:48]);
      bus_rd(CBIM_DIAG_HI);
      check(rd_v, ed[63:32]);
      bus_rd(CBIM_DIAG_LO);
      check(rd_v, ed[31:0]);
      bus_rd(CBIM_TYPE_ERR);
      check(rd_v, ed[31:16]);
      bus_rd(CBIM_SLV_DIAG);
      check(rd_v, ed[47:32]);
      bus_rd(CBIM_BRK_ERR);
      check(rd_v, ed[63:48]);
    end
  endtask : t_diag

  task automatic t_irq();
    bus_rd(CBIM_IRQ_STAT);
    check(rd_v, 64'hF);
    bus_wr(CBIM_IRQ_CLR, 32'hF);
    bus_wr(CBIM_IRQ_EN, 32'h1);
    bus_rd(CBIM_IRQ_EN);
    check(rd_v, 64'h1);
    @(posedge core_clk);
    unr <= 16'h0004;
    repeat (8) @(posedge core_clk);
    unr <= 16'h0;
    repeat (8) @(posedge core_clk);
    #1 check(irq, 64'h1);
    bus_wr(CBIM_IRQ_CLR, 32'h1);
    repeat (2) @(posedge core_clk);
    #1 check(irq, 64'h0);
    bus_wr(CBIM_IRQ_EN, 32'h0);
    @(posedge core_clk);
    unr <= 16'h8000;
    repeat (8) @(posedge core_clk);
    #1 check(irq, 64'h0);
    bus_rd(CBIM_IRQ_STAT);
    check(rd_v[0], 64'h1);
    @(posedge core_clk);
    unr <= 16'h0;
    bus_wr(CBIM_IRQ_CLR, 32'hF);
  endtask : t_irq

  task automatic t_link();
    int n;
    n = 0;
    bus_wr(CBIM_CTRL, 32'h1);
    while (tx_f !== 1'b1 && n < 200)
    begin
      @(posedge core_clk);
      #1 n++;
    end
    check(n < 200, 1'b1);
    check(tx_a, 64'h0);
    check(tx_d, exp_coil[0]);
    n = 0;
    while (tx_f !== 1'b0 && n < 1000)
    begin
      @(posedge core_clk);
      #1 n++;
    end
    check(n < 1000, 1'b1);
    check(rx_coils, exp_coil);
  endtask : t_link

  // ----
  // clock, reset, watchdog, main sequence
  // ----
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      complete_run();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    bus_req = '0;
    cfg_accepted = 1'b0;
    host_f = 1'b0;
    bus_f = 1'b0;
    aux_f = 1'b0;
    unr = '0;
    typ = '0;
    sd = '0;
    brk = '0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_out_image();
    t_diag();
    t_irq();
    t_link();
    complete_run();
  end
endmodule : testbench
